// >>> common/eipc_pkg.sv
// Constants, register map and types shared by the interrupt priority controller.
package eipc_pkg;

	// Number of interrupt sources: four external groups and one peripheral request.
	localparam int NSRC = 5;

	// Register word indexes on the bus, byte address is four times the index.
	localparam logic [3:0] IDX_COND = 4'h0;
	localparam logic [3:0] IDX_SENSE = 4'h1;
	localparam logic [3:0] IDX_PRIO0 = 4'h2;
	localparam logic [3:0] IDX_PRIO3 = 4'h5;
	localparam logic [3:0] IDX_STATUS = 4'h6;
	localparam logic [3:0] IDX_MASK = 4'h7;
	localparam logic [3:0] IDX_MODE = 4'h8;
	localparam logic [3:0] IDX_PEND = 4'h9;
	localparam logic [3:0] IDX_SERVICE = 4'ha;

	// Software priority codes as {hi, lo}.
	localparam logic [1:0] CODE_LVL0 = 2'b10;
	localparam logic [1:0] CODE_LVL1 = 2'b01;
	localparam logic [1:0] CODE_LVL2 = 2'b00;
	localparam logic [1:0] CODE_LVL3 = 2'b11;

	// Field positions.
	localparam int CC_HI_BIT = 5;
	localparam int CC_LO_BIT = 3;
	localparam int SENSE_B_SEL_LSB = 6;
	localparam int SENSE_B_POL_BIT = 5;
	localparam int SENSE_A_SEL_LSB = 3;
	localparam int SENSE_A_POL_BIT = 2;

	// Reset values and write masks.
	localparam logic [7:0] SENSE_RESET = 8'h00;
	localparam logic [7:0] SENSE_WMASK = 8'hfc;
	localparam logic [7:0] PRIO_RESET = 8'hff;
	localparam logic [3:0] STATUS_RESET = 4'h0;
	localparam logic [3:0] MASK_RESET = 4'h0;
	localparam logic [2:0] DEPTH_RESET = 3'h0;

	// Sensitivity select codes.
	localparam logic [1:0] SEL_FALL_LOW = 2'b00;
	localparam logic [1:0] SEL_RISE = 2'b01;
	localparam logic [1:0] SEL_FALL = 2'b10;
	localparam logic [1:0] SEL_BOTH = 2'b11;

	// Sources able to end the deep stop state: all external groups.
	localparam logic [NSRC-1:0] HALT_WAKE_MASK = 5'h0f;

	// Event bits of the sticky status register.
	localparam int EV_SERVICE = 0;
	localparam int EV_WAKE_WAIT = 1;
	localparam int EV_WAKE_HALT = 2;
	localparam int EV_SENSE_DENIED = 3;

	// Core power state, Gray coded along run, wait, halt.
	typedef enum logic [1:0] {
		PWR_RUN = 2'b00,
		PWR_WAIT = 2'b01,
		PWR_HALT = 2'b11
	} eipc_pwr_t;

endpackage : eipc_pkg

// >>> verilog/eipc_top.sv
// Interrupt priority, sensitivity and low-power wake controller with a Wishbone slave.
//
// Overview of operation
// - Priority bits hi/lo: 10 level0, 01 level1, 00 level2, 11 level3 disabled.
// - Taking an interrupt loads the priority bits from that source's priority register.
// - Enable, disable, return, halt, wait and pop instructions also change the bits.
// - Any request ends wait; only halt-capable requests end the deep stop.
// - First service after deep stop is a halt-capable source, normally arbitrated.
// - A higher pending non-halt-capable source is serviced right after that first one.
// - Concurrent mode never preempts a service; nested mode lets higher levels preempt.
// - Hardware order low to high: main, source 4 down to 0; breaks ties.
// - Nesting overflow raises no flag and no trap.
// - Sense register resets to zero; fields as listed; bits 1:0 stay clear.
// - Port-B select drives groups 2 and 3 with the four sensitivity codes.
// - Port-A select drives groups 0 and 1 with the same codes.
// - Polarity bit inverts sensitivity of port-B or port-A low nibble only.
// - Sense field writes take effect only at level 3, otherwise ignored.
// - The four software priority registers reset to all ones.
`timescale 1ns/1ps
module eipc_top (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [3:0] porta_pins,
	input wire logic [4:0] portb_pins,
	input wire logic [2:0] portf_pins,
	input wire logic periph_irq,
	input wire logic irq_enable_instr,
	input wire logic irq_disable_instr,
	input wire logic irq_return_instr,
	input wire logic halt_instr,
	input wire logic sleep_until_irq_instr,
	input wire logic cc_pop,
	input wire logic [7:0] cc_pop_value,
	input wire logic irq_ack,
	output logic prio_bit_hi,
	output logic prio_bit_lo,
	output logic irq_req,
	output logic [2:0] irq_vector,
	output logic cpu_wake,
	output logic cpu_waiting,
	output logic cpu_halted,
	output logic irq_out
);

	// Map a priority code to a numeric level.
	function automatic logic [1:0] eipc_level(input logic [1:0] code);
		logic [1:0] lvl;
		lvl = 2'h0;
		unique case (code)
			eipc_pkg::CODE_LVL0: lvl = 2'h0;
			eipc_pkg::CODE_LVL1: lvl = 2'h1;
			eipc_pkg::CODE_LVL2: lvl = 2'h2;
			eipc_pkg::CODE_LVL3: lvl = 2'h3;
		endcase
		return lvl;
	endfunction : eipc_level

	// Detect {edge, level} for one group; unused bits are padded high and stay idle.
	function automatic logic [1:0] eipc_detect(input logic [1:0] sel, input logic [3:0] cur,
		input logic [3:0] prev);
		logic [3:0] rise;
		logic [3:0] fall;
		logic [1:0] res;
		rise = cur & ~prev;
		fall = ~cur & prev;
		res = 2'h0;
		unique case (sel)
			eipc_pkg::SEL_FALL_LOW: res = {|fall, |(~cur)};
			eipc_pkg::SEL_RISE: res = {|rise, 1'b0};
			eipc_pkg::SEL_FALL: res = {|fall, 1'b0};
			eipc_pkg::SEL_BOTH: res = {|(rise | fall), 1'b0};
		endcase
		return res;
	endfunction : eipc_detect

	// Pick the eligible source of highest level; lower index wins a tie. Returns {valid, idx}.
	function automatic logic [3:0] eipc_pick(input logic [eipc_pkg::NSRC-1:0] elig,
		input logic [2*eipc_pkg::NSRC-1:0] codes);
		logic [3:0] best;
		logic [1:0] best_lvl;
		logic [1:0] lvl;
		best = 4'h0;
		best_lvl = 2'h0;
		for (int s = eipc_pkg::NSRC - 1; s >= 0; s--) begin
			lvl = eipc_level(codes[2*s +: 2]);
			if (elig[s] && (!best[3] || lvl >= best_lvl)) begin
				best = {1'b1, 3'(s)};
				best_lvl = lvl;
			end
		end
		return best;
	endfunction : eipc_pick

	logic [1:0] cc_code, ack_code;
	logic [7:0] sense;
	logic [7:0] prio_reg [4];
	logic [3:0] status, mask, pend, winner, grp_edge, grp_level, events, next_status, wb_idx;
	logic [2:0] depth;
	logic nested_mode, halt_first, wb_mapped, wr_fire, cc_wr, sense_wr, wake_wait, wake_halt;
	eipc_pkg::eipc_pwr_t pwr;
	logic [11:0] pin_s1, pin_s2, pin_prev;
	logic [eipc_pkg::NSRC-1:0] req, elig;
	logic [2*eipc_pkg::NSRC-1:0] src_codes;
	logic [31:0] next_rdata;

	assign prio_bit_hi = cc_code[1];
	assign prio_bit_lo = cc_code[0];

	// Bus decode; a write lands only at the edge where the master sees ack.
	assign wb_idx = wb_adr_i[5:2];
	assign wb_mapped = (wb_adr_i[7:6] == 2'h0) && (wb_idx <= eipc_pkg::IDX_SERVICE);
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && wb_mapped;
	assign cc_wr = wr_fire && (wb_idx == eipc_pkg::IDX_COND);
	assign sense_wr = wr_fire && (wb_idx == eipc_pkg::IDX_SENSE);

	// Two-stage pin synchroniser followed by a previous-sample stage for edges.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pin_s1 <= 12'hfff;
			pin_s2 <= 12'hfff;
			pin_prev <= 12'hfff;
		end else begin
			pin_s1 <= {portf_pins, portb_pins, porta_pins};
			pin_s2 <= pin_s1;
			pin_prev <= pin_s2;
		end
	end

	// Group sensitivity; polarity flips the sampled level so the both-edge code is unaffected.
	always_comb begin
		logic [1:0] d0;
		logic [1:0] d1;
		logic [1:0] d2;
		logic [1:0] d3;
		logic pa;
		logic pb;
		pa = sense[eipc_pkg::SENSE_A_POL_BIT];
		pb = sense[eipc_pkg::SENSE_B_POL_BIT];
		d0 = eipc_detect(sense[eipc_pkg::SENSE_A_SEL_LSB +: 2], pin_s2[3:0] ^ {4{pa}},
			pin_prev[3:0] ^ {4{pa}});
		d1 = eipc_detect(sense[eipc_pkg::SENSE_A_SEL_LSB +: 2], {1'b1, pin_s2[11:9]},
			{1'b1, pin_prev[11:9]});
		d2 = eipc_detect(sense[eipc_pkg::SENSE_B_SEL_LSB +: 2], pin_s2[7:4] ^ {4{pb}},
			pin_prev[7:4] ^ {4{pb}});
		d3 = eipc_detect(sense[eipc_pkg::SENSE_B_SEL_LSB +: 2], {3'b111, pin_s2[8]},
			{3'b111, pin_prev[8]});
		grp_edge = {d3[1], d2[1], d1[1], d0[1]};
		grp_level = {d3[0], d2[0], d1[0], d0[0]};
	end

	// Edge events are latched until serviced; a new edge in the ack cycle wins.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pend <= 4'h0;
		end else begin
			for (int g = 0; g < 4; g++) begin
				if (grp_edge[g]) begin
					pend[g] <= 1'b1;
				end else if (irq_ack && irq_vector == 3'(g)) begin
					pend[g] <= 1'b0;
				end
			end
		end
	end

	// Requests, eligibility and arbitration.
	always_comb begin
		req = {periph_irq, pend | grp_level};
		src_codes = {prio_reg[1][1:0], prio_reg[0]};
		ack_code = src_codes[2*irq_vector +: 2];
		for (int s = 0; s < eipc_pkg::NSRC; s++) begin
			elig[s] = req[s] && (eipc_level(src_codes[2*s +: 2]) > eipc_level(cc_code))
				&& (nested_mode || depth == eipc_pkg::DEPTH_RESET)
				&& (!halt_first || eipc_pkg::HALT_WAKE_MASK[s]);
		end
		winner = eipc_pick(elig, src_codes);
	end

	// Request to the core is withdrawn in the ack cycle and rebuilt only while running.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_req <= 1'b0;
			irq_vector <= 3'h0;
		end else if (irq_ack) begin
			irq_req <= 1'b0;
		end else begin
			irq_req <= winner[3] && (pwr == eipc_pkg::PWR_RUN);
			irq_vector <= winner[2:0];
		end
	end

	// Current priority bits; service entry outranks instructions, which outrank the bus.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cc_code <= eipc_pkg::CODE_LVL3;
		end else if (irq_ack) begin
			cc_code <= ack_code;
		end else if (irq_return_instr || cc_pop) begin
			cc_code <= {cc_pop_value[eipc_pkg::CC_HI_BIT], cc_pop_value[eipc_pkg::CC_LO_BIT]};
		end else if (irq_enable_instr || halt_instr || sleep_until_irq_instr) begin
			cc_code <= eipc_pkg::CODE_LVL0;
		end else if (irq_disable_instr) begin
			cc_code <= eipc_pkg::CODE_LVL3;
		end else if (cc_wr) begin
			cc_code <= {wb_dat_i[eipc_pkg::CC_HI_BIT], wb_dat_i[eipc_pkg::CC_LO_BIT]};
		end
	end

	// Nesting depth wraps silently; a deep stack is software's concern.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			depth <= eipc_pkg::DEPTH_RESET;
		end else if (irq_ack) begin
			depth <= depth + 3'h1;
		end else if (irq_return_instr && depth != eipc_pkg::DEPTH_RESET) begin
			depth <= depth - 3'h1;
		end
	end

	// Power state and wake; halt exit restricts the next service to halt-capable sources.
	assign wake_wait = (pwr == eipc_pkg::PWR_WAIT) && (|req);
	assign wake_halt = (pwr == eipc_pkg::PWR_HALT) && (|(req & eipc_pkg::HALT_WAKE_MASK));
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			pwr <= eipc_pkg::PWR_RUN;
			halt_first <= 1'b0;
			cpu_wake <= 1'b0;
		end else begin
			cpu_wake <= wake_wait || wake_halt;
			if (irq_ack) begin
				halt_first <= 1'b0;
			end
			unique case (pwr)
				eipc_pkg::PWR_RUN: begin
					if (halt_instr) begin
						pwr <= eipc_pkg::PWR_HALT;
					end else if (sleep_until_irq_instr) begin
						pwr <= eipc_pkg::PWR_WAIT;
					end
				end
				eipc_pkg::PWR_WAIT: begin
					if (wake_wait) begin
						pwr <= eipc_pkg::PWR_RUN;
					end
				end
				eipc_pkg::PWR_HALT: begin
					if (wake_halt) begin
						pwr <= eipc_pkg::PWR_RUN;
						halt_first <= 1'b1;
					end
				end
				default: pwr <= eipc_pkg::PWR_RUN;
			endcase
		end
	end

	// State flags for the core, registered for clean outputs.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cpu_waiting <= 1'b0;
			cpu_halted <= 1'b0;
		end else begin
			cpu_waiting <= (pwr == eipc_pkg::PWR_WAIT);
			cpu_halted <= (pwr == eipc_pkg::PWR_HALT);
		end
	end

	// Sensitivity register; reserved bits are forced clear on every accepted write.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sense <= eipc_pkg::SENSE_RESET;
		end else if (sense_wr && cc_code == eipc_pkg::CODE_LVL3) begin
			sense <= wb_dat_i[7:0] & eipc_pkg::SENSE_WMASK;
		end
	end

	// Software priority registers and mode.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			for (int k = 0; k < 4; k++) begin
				prio_reg[k] <= eipc_pkg::PRIO_RESET;
			end
			nested_mode <= 1'b0;
			mask <= eipc_pkg::MASK_RESET;
		end else if (wr_fire) begin
			if (wb_idx >= eipc_pkg::IDX_PRIO0 && wb_idx <= eipc_pkg::IDX_PRIO3) begin
				prio_reg[2'(wb_idx - eipc_pkg::IDX_PRIO0)] <= wb_dat_i[7:0];
			end
			if (wb_idx == eipc_pkg::IDX_MODE) begin
				nested_mode <= wb_dat_i[0];
			end
			if (wb_idx == eipc_pkg::IDX_MASK) begin
				mask <= wb_dat_i[3:0];
			end
		end
	end

	// Sticky events, write one to clear; a set in the same cycle wins over the clear.
	always_comb begin
		events = 4'h0;
		events[eipc_pkg::EV_SERVICE] = irq_ack;
		events[eipc_pkg::EV_WAKE_WAIT] = wake_wait;
		events[eipc_pkg::EV_WAKE_HALT] = wake_halt;
		events[eipc_pkg::EV_SENSE_DENIED] = sense_wr && (cc_code != eipc_pkg::CODE_LVL3);
		next_status = status;
		if (wr_fire && wb_idx == eipc_pkg::IDX_STATUS) begin
			next_status = status & ~wb_dat_i[3:0];
		end
		next_status = next_status | events;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status <= eipc_pkg::STATUS_RESET;
			irq_out <= 1'b0;
		end else begin
			status <= next_status;
			irq_out <= |(next_status & mask);
		end
	end

	// Read mux; unmapped addresses read zero and still get an ack.
	always_comb begin
		next_rdata = 32'h0;
		if (wb_mapped) begin
			unique case (wb_idx)
				eipc_pkg::IDX_COND: begin
					next_rdata[eipc_pkg::CC_HI_BIT] = cc_code[1];
					next_rdata[eipc_pkg::CC_LO_BIT] = cc_code[0];
				end
				eipc_pkg::IDX_SENSE: next_rdata[7:0] = sense;
				eipc_pkg::IDX_STATUS: next_rdata[3:0] = status;
				eipc_pkg::IDX_MASK: next_rdata[3:0] = mask;
				eipc_pkg::IDX_MODE: next_rdata[0] = nested_mode;
				eipc_pkg::IDX_PEND: next_rdata[4:0] = req;
				eipc_pkg::IDX_SERVICE: next_rdata[5:0] = {halt_first, pwr, depth};
				default: next_rdata[7:0] = prio_reg[2'(wb_idx - eipc_pkg::IDX_PRIO0)];
			endcase
		end
	end

	// Single-wait-state slave: ack one cycle after the request, dropped the next cycle.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= next_rdata;
			end
		end
	end

	sense_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		sense_wr && cc_code != eipc_pkg::CODE_LVL3 |=> $stable(sense))
		else $error("Sense register changed outside level 3.");
	sense_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		sense_wr && cc_code == eipc_pkg::CODE_LVL3
		|=> sense == ($past(wb_dat_i[7:0]) & eipc_pkg::SENSE_WMASK))
		else $error("Accepted sense write not stored with reserved bits clear.");
	entry_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		irq_ack |=> cc_code == $past(ack_code))
		else $error("Priority bits not loaded from the serviced source.");
	rim_level_a: assert property (@(posedge clk) disable iff (!reset_n)
		irq_enable_instr && !irq_ack && !irq_return_instr && !cc_pop
		|=> cc_code == eipc_pkg::CODE_LVL0 ##1 !irq_req || cc_code != eipc_pkg::CODE_LVL3)
		else $error("Enable instruction did not set level 0.");
	concurrent_a: assert property (@(posedge clk) disable iff (!reset_n)
		!nested_mode && depth != eipc_pkg::DEPTH_RESET && !irq_ack && !irq_return_instr
		|=> !irq_req)
		else $error("Preemption requested in concurrent mode.");
	halt_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		pwr == eipc_pkg::PWR_HALT && (req & eipc_pkg::HALT_WAKE_MASK) == 5'h00
		|=> pwr == eipc_pkg::PWR_HALT)
		else $error("Deep stop left without a halt-capable request.");
	wait_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
		pwr == eipc_pkg::PWR_WAIT && |req |=> pwr == eipc_pkg::PWR_RUN && cpu_wake)
		else $error("Wait state not left on a request.");
	halt_first_a: assert property (@(posedge clk) disable iff (!reset_n)
		halt_first && irq_req |-> eipc_pkg::HALT_WAKE_MASK[irq_vector])
		else $error("First service after deep stop is not halt-capable.");
	edge_pend_a: assert property (@(posedge clk) disable iff (!reset_n)
		pin_s2[8] && !pin_prev[8] && sense[eipc_pkg::SENSE_B_SEL_LSB +: 2] == eipc_pkg::SEL_RISE
		|=> pend[3])
		else $error("Rising edge on group 3 not latched.");

endmodule : eipc_top

// >>> testbench/eipc_core_model.sv
// Core-side partner that acknowledges interrupt requests after a programmable delay.
`timescale 1ns/1ps
module eipc_core_model (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic irq_req,
	input wire logic [2:0] irq_vector,
	input wire logic [3:0] ack_delay,
	output logic irq_ack,
	output logic [2:0] last_vector,
	output logic [7:0] taken_count
);
	logic [3:0] wait_cnt;

	// A request that vanishes before the ack is decided restarts the delay; one that drops after the edge that decides the ack is still acked.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq_ack <= 1'b0;
			wait_cnt <= 4'h0;
		end else if (irq_req && !irq_ack && wait_cnt >= ack_delay) begin
			irq_ack <= 1'b1;
			wait_cnt <= 4'h0;
		end else begin
			irq_ack <= 1'b0;
			wait_cnt <= (irq_req && !irq_ack) ? wait_cnt + 4'h1 : 4'h0;
		end
	end

	// The vector is logged at the edge where the controller samples the ack.
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			last_vector <= 3'h0;
			taken_count <= 8'h00;
		end else if (irq_ack && irq_req) begin
			last_vector <= irq_vector;
			taken_count <= taken_count + 8'h01;
		end
	end
endmodule : eipc_core_model

// >>> testbench/testbench.sv
// Self-checking testbench for the interrupt priority controller.
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic cyc = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic [3:0] pv = 4'hf;
	logic periph = 1'b0;
	logic [5:0] instr_v = 6'h00;
	logic [7:0] pop = 8'h00;
	logic [3:0] ack_delay = 4'h0;
	logic core_ack, prio_hi, prio_lo, irq_req, cpu_wake, cpu_waiting, cpu_halted, irq_out;
	logic [2:0] irq_vector, last_vec;
	logic [7:0] taken_count;
	logic [31:0] rd;
	logic [1:0] g;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int takes = 0;
	int n;
	// Row: [13:12] group, [11:4] sense value, [1] pin level, [0] expected pending.
	localparam logic [15:0] ROWS [18] = '{16'h0080, 16'h0083, 16'h0101, 16'h0102, 16'h00c1,
		16'h0143, 16'h0181, 16'h01c3, 16'h10c0, 16'h10c3, 16'h2601, 16'h3600, 16'h3603,
		16'h2a03, 16'h0043, 16'h0040, 16'h0001, 16'h0002};

	eipc_top i_eipc_top (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .porta_pins({4{pv[0]}}), .portb_pins({pv[3], {4{pv[2]}}}),
		.portf_pins({3{pv[1]}}), .periph_irq(periph), .irq_enable_instr(instr_v[0]),
		.irq_disable_instr(instr_v[1]), .irq_return_instr(instr_v[2]), .halt_instr(instr_v[3]),
		.sleep_until_irq_instr(instr_v[4]), .cc_pop(instr_v[5]), .cc_pop_value(pop),
		.irq_ack(core_ack), .prio_bit_hi(prio_hi), .prio_bit_lo(prio_lo), .irq_req(irq_req),
		.irq_vector(irq_vector), .cpu_wake(cpu_wake), .cpu_waiting(cpu_waiting),
		.cpu_halted(cpu_halted), .irq_out(irq_out));

	eipc_core_model i_eipc_core_model (.clk(clk), .reset_n(reset_n), .irq_req(irq_req),
		.irq_vector(irq_vector), .ack_delay(ack_delay), .irq_ack(core_ack),
		.last_vector(last_vec), .taken_count(taken_count));

	// Free-running 125 MHz clock.
	always #4 clk = ~clk;

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : wrap_up

	// A hung handshake must not stall the run forever.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Classic single cycle; request held until ack is sampled high, read data taken there.
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		@(posedge clk);
		while (ack !== 1'b1 && k < 50) begin
			@(posedge clk);
			k++;
		end
		if (k >= 50) miscompares++;
		rd = rdat;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask : wb

	// Bits: 0 enable, 1 disable, 2 return, 3 halt, 4 wait, 5 pop; one extra edge lets it land.
	task automatic instr(input logic [5:0] v, input logic [7:0] p);
		@(posedge clk);
		instr_v <= v;
		pop <= p;
		@(posedge clk);
		instr_v <= 6'h00;
		@(posedge clk);
	endtask : instr

	// Pending is set three edges after the pin moves, so four edges suffice.
	task automatic pins(input logic [3:0] v);
		@(posedge clk);
		pv <= v;
		repeat (4) @(posedge clk);
	endtask : pins

	task automatic take(input logic [2:0] v);
		int k;
		k = 0;
		while (taken_count === 8'(takes) && k < 60) begin
			@(posedge clk);
			k++;
		end
		if (k >= 60) miscompares++;
		takes++;
		check({29'h0, last_vec}, {29'h0, v});
	endtask : take

	task automatic chk_prio(input logic [1:0] exp);
		check({30'h0, prio_hi, prio_lo}, {30'h0, exp});
	endtask : chk_prio

	// Services one pending group from level 0 and returns to level 3.
	task automatic drain(input logic [2:0] v);
		instr(6'h01, 8'h00);
		take(v);
		chk_prio(eipc_pkg::CODE_LVL3);
		instr(6'h04, 8'h28);
	endtask : drain

	initial begin
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 18; i++) begin
			g = ROWS[i][13:12];
			wb(1'b1, 8'h04, ROWS[i][11:4]);
			pins(ROWS[i][1] ? (pv | (4'h1 << g)) : (pv & ~(4'h1 << g)));
			wb(1'b0, 8'h24, 8'h00);
			check({31'h0, rd[g]}, {31'h0, ROWS[i][0]});
			if (ROWS[i][0] && (ROWS[i][11:4] & 8'hd8) != 8'h00) drain({1'b0, g});
		end
		// Status holds service events but the mask keeps the output low.
		check({31'h0, irq_out}, 32'h0);
		wb(1'b1, 8'h1c, 8'h08);
		instr(6'h01, 8'h00);
		chk_prio(eipc_pkg::CODE_LVL0);
		wb(1'b1, 8'h04, 8'h18);
		wb(1'b0, 8'h04, 8'h00);
		check(rd, 32'h0);
		wb(1'b0, 8'h18, 8'h00);
		check(rd, 32'h09);
		check({31'h0, irq_out}, 32'h1);
		wb(1'b1, 8'h18, 8'h0f);
		wb(1'b0, 8'h18, 8'h00);
		check(rd, 32'h0);
		check({31'h0, irq_out}, 32'h0);
		instr(6'h20, 8'h08);
		chk_prio(eipc_pkg::CODE_LVL1);
		wb(1'b0, 8'h00, 8'h00);
		check(rd, 32'h08);
		instr(6'h20, 8'h00);
		chk_prio(eipc_pkg::CODE_LVL2);
		instr(6'h02, 8'h00);
		chk_prio(eipc_pkg::CODE_LVL3);
		wb(1'b1, 8'h04, 8'hff);
		wb(1'b0, 8'h04, 8'h00);
		check(rd, 32'hfc);
		wb(1'b1, 8'h08, 8'h00);
		// Mid-run reset must restore the priority bits and the sense, priority and status registers; unmapped space is probed too.
		@(posedge clk);
		reset_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		takes = 0;
		chk_prio(eipc_pkg::CODE_LVL3);
		wb(1'b1, 8'h44, 8'h18);
		wb(1'b0, 8'h44, 8'h00);
		check(rd, 32'h0);
		wb(1'b0, 8'h04, 8'h00);
		check(rd, 32'h0);
		for (int k = 0; k < 4; k++) begin
			wb(1'b0, 8'h08 + 8'(4 * k), 8'h00);
			check(rd, 32'hff);
		end
		wb(1'b0, 8'h18, 8'h00);
		check(rd, 32'h0);
		// Bus writes to the priority bits land and read back in place.
		wb(1'b1, 8'h00, 8'h20);
		wb(1'b0, 8'h00, 8'h00);
		check(rd, 32'h20);
		chk_prio(eipc_pkg::CODE_LVL0);
		wb(1'b1, 8'h00, 8'h28);
		// Concurrent mode: the running service at level 1 is not preempted.
		wb(1'b1, 8'h04, 8'hd8);
		wb(1'b1, 8'h08, 8'hfd);
		instr(6'h01, 8'h00);
		pins(4'b1110);
		take(3'h0);
		chk_prio(eipc_pkg::CODE_LVL1);
		pins(4'b0010);
		repeat (10) @(posedge clk);
		check({24'h0, taken_count}, 32'(takes));
		instr(6'h04, 8'h20);
		take(3'h2);
		instr(6'h04, 8'h20);
		take(3'h3);
		instr(6'h04, 8'h20);
		// Nested mode with a slow core: level 3 preempts level 1.
		ack_delay <= 4'h3;
		wb(1'b1, 8'h20, 8'h01);
		pins(4'b0011);
		take(3'h0);
		pins(4'b0111);
		take(3'h2);
		instr(6'h04, 8'h08);
		instr(6'h04, 8'h20);
		wb(1'b1, 8'h20, 8'h00);
		// Any source ends wait, including the peripheral one.
		instr(6'h10, 8'h00);
		// The waiting flag lags the state by one edge, so let it settle first.
		@(posedge clk);
		check({31'h0, cpu_waiting}, 32'h1);
		periph <= 1'b1;
		n = 0;
		while (cpu_wake !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		check({31'h0, cpu_wake}, 32'h1);
		take(3'h4);
		periph <= 1'b0;
		instr(6'h04, 8'h20);
		// Deep stop ignores the peripheral; a pin wakes it and is served first.
		instr(6'h08, 8'h00);
		periph <= 1'b1;
		repeat (10) @(posedge clk);
		check({31'h0, cpu_halted}, 32'h1);
		check({24'h0, taken_count}, 32'(takes));
		pins(4'b0110);
		take(3'h0);
		check({31'h0, cpu_halted}, 32'h0);
		instr(6'h04, 8'h20);
		take(3'h4);
		periph <= 1'b0;
		instr(6'h04, 8'h20);
		wrap_up();
	end
endmodule : testbench
